// >>> cpsr_regs.vh
// Constants for the status, program counter low and table pointer block
`ifndef CPSR_REGS_VH
`define CPSR_REGS_VH
`define CPSR_ADDR_W 8
`define CPSR_PC_W 11
`define CPSR_ADDR_PCL 8'h06
`define CPSR_ADDR_TBLO 8'h07
`define CPSR_ADDR_TBHI 8'h08
`define CPSR_ADDR_TBHL 8'h09
`define CPSR_ADDR_FLAGS 8'h0a
`define CPSR_BIT_CARRY 0
`define CPSR_BIT_HALF 1
`define CPSR_BIT_NULL 2
`define CPSR_BIT_SWRAP 3
`define CPSR_BIT_HALT 4
`define CPSR_BIT_WDOG 5
`define CPSR_ARITH_MASK 8'h0f
`define CPSR_FLAGS_RST 6'h00
`define CPSR_PC_RST 11'h000
`define CPSR_OP_NONE 3'h0
`define CPSR_OP_ADD 3'h1
`define CPSR_OP_SUB 3'h2
`define CPSR_OP_LOGIC 3'h3
`define CPSR_OP_RLC 3'h4
`define CPSR_OP_RRC 3'h5
`endif

// >>> cpsr_alu_flags.v
// Flag generator for arithmetic, logic and rotate-through-carry results
`timescale 1ns/10ps
`include "cpsr_regs.vh"
module cpsr_alu_flags
(
   input wire [2:0] op_i,
   input wire [7:0] a_i,
   input wire [7:0] b_i,
   input wire carry_i,
   output reg [7:0] result_o,
   output reg carry_o,
   output reg half_o,
   output reg null_o,
   output reg swrap_o,
   output reg arith_o
);
   reg [8:0] sum;
   reg [4:0] nib;
   reg [7:0] bx;
   reg cin7;
   always @*
   begin
      bx = (op_i == `CPSR_OP_SUB) ? ~b_i : b_i;
      // Subtract as a + ~b + 1 so carry out means no borrow
      sum = {1'b0, a_i} + {1'b0, bx} + {8'h00, (op_i == `CPSR_OP_SUB)};
      nib = {1'b0, a_i[3:0]} + {1'b0, bx[3:0]}
         + {4'h0, (op_i == `CPSR_OP_SUB)};
      cin7 = sum[7] ^ a_i[7] ^ bx[7];
      result_o = a_i;
      carry_o = carry_i;
      half_o = nib[4];
      swrap_o = cin7 ^ sum[8];
      arith_o = 1'b0;
      case (op_i)
         `CPSR_OP_ADD, `CPSR_OP_SUB:
         begin
            result_o = sum[7:0];
            carry_o = sum[8];
            arith_o = 1'b1;
         end
         `CPSR_OP_LOGIC:
            result_o = a_i;
         `CPSR_OP_RLC:
         begin
            result_o = {a_i[6:0], carry_i};
            carry_o = a_i[7];
         end
         `CPSR_OP_RRC:
         begin
            result_o = {carry_i, a_i[7:1]};
            carry_o = a_i[0];
         end
         default:
            result_o = a_i;
      endcase
      null_o = (result_o == 8'h00);
   end
endmodule // cpsr_alu_flags

// >>> cpsr_core.v
// Status flags, program counter low byte and table pointer registers
// Functional notes
// - A write to the PC low byte jumps within the current page.
// - Such a jump inserts one dummy cycle before the target runs.
// - A table read puts the high byte in the latch, low byte to memory.
// - Data writes to the status register never touch the system flags.
// - Carry is add carry or subtract no-borrow, and rotates through.
// - Half flag is low nibble carry or no-borrow.
// - Null flag is set when the result is zero.
// - Signed wrap flag is carry into MSB xor carry out of MSB.
// - Halt flag clears at power-up and watchdog clear, sets on halt.
// - Watchdog flag clears at power-up, watchdog clear and halt.
// - Calls push only the return address, not flags.
// - Status bits 7 and 6 read zero and ignore writes.
// - The four arithmetic flags are writable like ordinary bits.
`timescale 1ns/10ps
`include "cpsr_regs.vh"
module cpsr_core
#(
   parameter PC_W = `CPSR_PC_W
)
(
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire step_i,
   input wire call_i,
   input wire [PC_W-1:0] call_target_i,
   input wire [2:0] alu_op_i,
   input wire [7:0] alu_a_i,
   input wire [7:0] alu_b_i,
   input wire wr_i,
   input wire [7:0] wr_addr_i,
   input wire [7:0] wr_data_i,
   input wire [7:0] rd_addr_i,
   input wire table_read_i,
   input wire [15:0] rom_word_i,
   input wire halt_i,
   input wire wdt_clear_i,
   input wire wdt_timeout_i,
   output reg [PC_W-1:0] pc_o,
   output reg [PC_W-1:0] push_addr_o,
   output reg push_o,
   output reg dummy_o,
   output reg [15:0] rom_addr_o,
   output reg [7:0] table_low_o,
   output reg table_low_valid_o,
   output reg [7:0] alu_result_o,
   output reg [7:0] rd_data_o,
   output reg [7:0] flags_o
);
   reg [PC_W-1:0] pc;
   reg dummy;
   reg [7:0] tbl_lo;
   reg [7:0] tbl_hi;
   reg [7:0] tbl_latch;
   reg [5:0] flags;
   reg [5:0] next_flags;
   reg [7:0] rd_mux;
   wire [7:0] res;
   wire c_o;
   wire h_o;
   wire n_o;
   wire v_o;
   wire arith;
   wire pc_wr;
   wire st_wr;
   wire [PC_W-1:0] page_jump;
   reg [PC_W-1:0] next_pc;
   reg next_dummy;
   wire [PC_W-1:0] pc_inc;
   wire tbl_lo_wr;
   wire tbl_hi_wr;
   wire tbl_rd;

   cpsr_alu_flags u_alu
   (
      .op_i(alu_op_i),
      .a_i(alu_a_i),
      .b_i(alu_b_i),
      .carry_i(flags[`CPSR_BIT_CARRY]),
      .result_o(res),
      .carry_o(c_o),
      .half_o(h_o),
      .null_o(n_o),
      .swrap_o(v_o),
      .arith_o(arith)
   );

   assign pc_wr = step_i & ~dummy & wr_i & (wr_addr_i == `CPSR_ADDR_PCL);
   assign st_wr = step_i & ~dummy & wr_i & (wr_addr_i == `CPSR_ADDR_FLAGS);
   assign page_jump = {pc[PC_W-1:8], wr_data_i};
   assign pc_inc = pc + {{(PC_W-1){1'b0}}, 1'b1};
   // A step spent on the dummy slot must not touch the pointers
   assign tbl_lo_wr = step_i & ~dummy & wr_i & (wr_addr_i == `CPSR_ADDR_TBLO);
   assign tbl_hi_wr = step_i & ~dummy & wr_i & (wr_addr_i == `CPSR_ADDR_TBHI);
   assign tbl_rd = step_i & ~dummy & table_read_i;

   always @*
   begin
      next_pc = pc;
      next_dummy = dummy;
      if (step_i)
      begin
         // A step landing in the dummy slot is spent doing nothing
         if (dummy)
            next_dummy = 1'b0;
         else if (pc_wr)
         begin
            next_pc = page_jump;
            next_dummy = 1'b1;
         end
         else if (call_i)
            next_pc = call_target_i;
         else if (!halt_i)
            next_pc = pc_inc;
      end
   end

   always @*
   begin
      next_flags = flags;
      if (step_i && !dummy && alu_op_i != `CPSR_OP_NONE)
      begin
         next_flags[`CPSR_BIT_CARRY] = c_o;
         next_flags[`CPSR_BIT_NULL] = n_o;
         if (arith)
         begin
            next_flags[`CPSR_BIT_HALF] = h_o;
            next_flags[`CPSR_BIT_SWRAP] = v_o;
         end
      end
      // Direct write wins over flag update of the same step
      if (st_wr)
         next_flags[3:0] = wr_data_i[3:0];
      if (step_i && !dummy && wdt_clear_i)
      begin
         next_flags[`CPSR_BIT_HALT] = 1'b0;
         next_flags[`CPSR_BIT_WDOG] = 1'b0;
      end
      if (step_i && !dummy && halt_i)
      begin
         next_flags[`CPSR_BIT_HALT] = 1'b1;
         next_flags[`CPSR_BIT_WDOG] = 1'b0;
      end
      // Time-out is an event; it wins over any clear in the same cycle
      if (wdt_timeout_i)
         next_flags[`CPSR_BIT_WDOG] = 1'b1;
   end

   always @*
   begin
      case (rd_addr_i)
         `CPSR_ADDR_PCL: rd_mux = pc[7:0];
         `CPSR_ADDR_TBLO: rd_mux = tbl_lo;
         `CPSR_ADDR_TBHI: rd_mux = tbl_hi;
         `CPSR_ADDR_TBHL: rd_mux = tbl_latch;
         `CPSR_ADDR_FLAGS: rd_mux = {2'b00, flags};
         default: rd_mux = 8'h00;
      endcase
   end

   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pc <= `CPSR_PC_RST;
         dummy <= 1'b0;
         flags <= `CPSR_FLAGS_RST;
         pc_o <= `CPSR_PC_RST;
         push_addr_o <= `CPSR_PC_RST;
         push_o <= 1'b0;
         dummy_o <= 1'b0;
         alu_result_o <= 8'h00;
         rd_data_o <= 8'h00;
         flags_o <= 8'h00;
      end
      else
      begin
         pc <= next_pc;
         dummy <= next_dummy;
         flags <= next_flags;
         push_o <= 1'b0;
         if (step_i && !dummy && !pc_wr && call_i)
         begin
            // Only the return address is pushed, flags stay put
            push_addr_o <= pc_inc;
            push_o <= 1'b1;
         end
         pc_o <= pc;
         dummy_o <= dummy;
         alu_result_o <= res;
         rd_data_o <= rd_mux;
         flags_o <= {2'b00, next_flags};
      end
   end

   // Table pointers step through plain writes, like any data register
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tbl_lo <= 8'h00;
         tbl_hi <= 8'h00;
         tbl_latch <= 8'h00;
         table_low_o <= 8'h00;
         table_low_valid_o <= 1'b0;
         rom_addr_o <= 16'h0000;
      end
      else
      begin
         table_low_valid_o <= tbl_rd;
         if (tbl_lo_wr)
            tbl_lo <= wr_data_i;
         if (tbl_hi_wr)
            tbl_hi <= wr_data_i;
         if (tbl_rd)
         begin
            tbl_latch <= rom_word_i[15:8];
            table_low_o <= rom_word_i[7:0];
         end
         rom_addr_o <= {tbl_hi, tbl_lo};
      end
   end
endmodule // cpsr_core

// >>> cpsr_core_monitor.sv
// Checker on status flags, page jump and return push
`timescale 1ns/10ps
module cpsr_core_monitor #(parameter PC_W = 11)
(
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire step_i,
   input wire call_i,
   input wire wr_i,
   input wire [7:0] wr_addr_i,
   input wire [7:0] wr_data_i,
   input wire halt_i,
   input wire wdt_clear_i,
   input wire wdt_timeout_i,
   input wire [PC_W-1:0] pc_o,
   input wire push_o,
   input wire dummy_o,
   input wire [7:0] flags_o
);
   wire ev = wdt_timeout_i | step_i & (halt_i | wdt_clear_i);
   reg dmy;
   // Own copy of the dummy slot, so a consumed step is not judged
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         dmy <= 1'b0;
      else if (step_i)
         dmy <= !dmy && wr_i && wr_addr_i == 8'h06;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence pcl_wr;
      step_i && !dmy && wr_i && wr_addr_i == 8'h06;
   endsequence
   sequence halt_st;
      step_i && !dmy && halt_i && !wdt_timeout_i;
   endsequence
   a_top_zero: assert property (
      flags_o[7:6] == 2'b00) else $error("top bits set");
   a_wdog_sets: assert property (
      wdt_timeout_i |-> ##[1:2] flags_o[5]) else $error("timeout unset");
   a_halt_sets: assert property (
      halt_st |-> ##[1:2] flags_o[4]) else $error("halt flag unset");
   a_clear_both: assert property (
      step_i && !dmy && wdt_clear_i && !halt_i && !wdt_timeout_i |-> ##[1:2]
      flags_o[5:4] == 2'b00) else $error("system flags kept");
   a_sys_keep: assert property (
      $changed(flags_o[5:4]) |-> $past(ev) || $past(ev, 2))
      else $error("system flags changed");
   a_pcl_dummy: assert property (
      pcl_wr |-> ##[1:2] dummy_o) else $error("no dummy cycle");
   a_pcl_low: assert property (
      pcl_wr |-> ##2 pc_o[7:0] == $past(wr_data_i, 2))
      else $error("jump target wrong");
   a_push_call: assert property (
      step_i && !dmy && call_i && !(wr_i && wr_addr_i == 8'h06)
      |-> ##[1:2] push_o) else $error("no push");
endmodule // cpsr_core_monitor
bind cpsr_core cpsr_core_monitor #(.PC_W(PC_W)) mon (.sys_clk_i, .rst_b_i,
   .step_i, .call_i, .wr_i, .wr_addr_i, .wr_data_i, .halt_i, .wdt_clear_i,
   .wdt_timeout_i, .pc_o, .push_o, .dummy_o, .flags_o);

// >>> cpsr_core_bench.sv
// Self-checking bench for the status and pointer block
`timescale 1ns/10ps
`include "cpsr_regs.vh"
module cpsr_core_bench;
   reg sys_clk_i = 0, rst_b_i = 0, step_i = 0, call_i = 0, wr_i = 0;
   reg table_read_i = 0, halt_i = 0, wdt_clear_i = 0, wdt_timeout_i = 0;
   reg pend = 0, pd = 0;
   reg [10:0] call_target_i = 0;
   reg [2:0] alu_op_i = 0;
   reg [7:0] alu_a_i = 0, alu_b_i = 0, wr_addr_i = 0, wr_data_i = 0;
   reg [7:0] rd_addr_i = 0, a, b;
   reg [7:0] res_seen = 0, er8 = 0;
   reg [3:0] f = 0;
   reg [2:0] opc = 0;
   reg [15:0] rom_word_i = 0, m;
   wire [10:0] pc_o, push_addr_o;
   wire push_o, dummy_o, table_low_valid_o;
   wire [15:0] rom_addr_o;
   wire [7:0] table_low_o, alu_result_o, rd_data_o, flags_o;
   reg [15:0] q [$];
   integer n_fail = 0, cmp_count = 0, i, n_tbl = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   cpsr_core uut (.sys_clk_i, .rst_b_i, .step_i, .call_i, .call_target_i,
      .alu_op_i, .alu_a_i, .alu_b_i, .wr_i, .wr_addr_i, .wr_data_i,
      .rd_addr_i, .table_read_i, .rom_word_i, .halt_i, .wdt_clear_i,
      .wdt_timeout_i, .pc_o, .push_addr_o, .push_o, .dummy_o, .rom_addr_o,
      .table_low_o, .table_low_valid_o, .alu_result_o, .rd_data_o, .flags_o);
   task chk(input [15:0] g, input [15:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e)
         begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // Read data lands one edge after the address
   always @(posedge sys_clk_i)
   begin
      if (pd)
      begin
         m = q.pop_front();
         chk(rd_data_o & m[15:8], m[7:0]);
      end
      if (table_low_valid_o)
      begin
         n_tbl = n_tbl + 1;
         chk(table_low_o, 8'hcd);
      end
      pd <= pend;
   end
   // Idle edge after each step so no strobe drops and rises at once
   task go;
      begin
         step_i = 1;
         @(posedge sys_clk_i);
         #1;
         {step_i, call_i, wr_i, table_read_i, halt_i, wdt_clear_i} = 0;
         alu_op_i = 0;
         res_seen = alu_result_o;
         @(posedge sys_clk_i);
         #1;
      end
   endtask
   task wr(input [7:0] ad, input [7:0] d);
      begin
         wr_i = 1;
         wr_addr_i = ad;
         wr_data_i = d;
         go;
      end
   endtask
   // Two cycles per read keeps pend from toggling twice in one step
   task rd(input [7:0] ad, input [15:0] e);
      begin
         rd_addr_i = ad;
         q.push_back(e);
         pend = 1;
         @(posedge sys_clk_i);
         #1 pend = 0;
         @(posedge sys_clk_i);
         #1;
      end
   endtask
   task ao(input [2:0] op, input [7:0] x, input [7:0] er, input [15:0] e);
      begin
         alu_op_i = op;
         alu_a_i = x;
         go;
         chk(res_seen, er);
         rd(`CPSR_ADDR_FLAGS, e);
      end
   endtask
   task pulse_wdt;
      begin
         wdt_timeout_i = 1;
         @(posedge sys_clk_i);
         #1 wdt_timeout_i = 0;
      end
   endtask
   function [3:0] fl(input [2:0] op, input [7:0] x, input [7:0] y);
      reg [8:0] r;
      begin
         r = (op == `CPSR_OP_ADD) ? x + y : x - y;
         fl[0] = (op == `CPSR_OP_ADD) ? r[8] : !r[8];
         fl[1] = (op == `CPSR_OP_ADD) ? (x[3:0] + y[3:0] > 15)
            : (x[3:0] >= y[3:0]);
         fl[2] = r[7:0] == 0;
         fl[3] = ((x[7] ^ y[7]) == (op == `CPSR_OP_SUB)) && (r[7] != x[7]);
      end
   endfunction
   task finish_test;
      begin
         $display("compares %0d mismatches %0d", cmp_count, n_fail);
         if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial
   begin
      i = $urandom(32'h98cba129);
      repeat (12) @(posedge sys_clk_i);
      #1 rst_b_i = 1;
      rd(`CPSR_ADDR_FLAGS, 16'hff00);
      wr(`CPSR_ADDR_FLAGS, 8'hff);
      rd(`CPSR_ADDR_FLAGS, 16'hff0f);
      for (i = 0; i < 40; i = i + 1)
      begin
         a = $urandom;
         b = (i < 4) ? a : $urandom;
         alu_b_i = b;
         opc = (i % 2) ? `CPSR_OP_SUB : `CPSR_OP_ADD;
         f = fl(opc, a, b);
         er8 = (i % 2) ? a - b : a + b;
         ao(opc, a, er8, {12'h0f0, f});
      end
      ao(`CPSR_OP_LOGIC, 8'h00, 8'h00, 16'h0404);
      ao(`CPSR_OP_RLC, 8'h80, {7'h00, f[0]}, 16'h0101);
      ao(`CPSR_OP_RRC, 8'h00, 8'h80, 16'h0100);
      halt_i = 1;
      go;
      wr(`CPSR_ADDR_FLAGS, 8'h00);
      rd(`CPSR_ADDR_FLAGS, 16'h3f10);
      pulse_wdt;
      rd(`CPSR_ADDR_FLAGS, 16'h3030);
      halt_i = 1;
      go;
      rd(`CPSR_ADDR_FLAGS, 16'h3010);
      pulse_wdt;
      wdt_clear_i = 1;
      go;
      rd(`CPSR_ADDR_FLAGS, 16'h3000);
      call_i = 1;
      call_target_i = 11'h5a3;
      go;
      chk(push_addr_o, 11'h02f);
      wr(`CPSR_ADDR_PCL, 8'h40);
      wr(`CPSR_ADDR_FLAGS, 8'h0f);
      chk(pc_o, 11'h540);
      rd(`CPSR_ADDR_FLAGS, 16'h0f00);
      rd(`CPSR_ADDR_PCL, 16'hff40);
      wr(`CPSR_ADDR_TBLO, 8'h34);
      wr(`CPSR_ADDR_TBHI, 8'h12);
      rom_word_i = 16'habcd;
      table_read_i = 1;
      go;
      chk(rom_addr_o, 16'h1234);
      rd(`CPSR_ADDR_TBHL, 16'hffab);
      chk(n_tbl, 1);
      finish_test;
   end
endmodule // cpsr_core_bench
